// >>> design/uphy_reset_config.sv
// Purpose: USB3 PHY power-on reset sequencing and config register port.
// Assumes: Controlling logic drives reset and commands from another domain.
// Notes: Registers are reached over AHB-Lite with zero wait states.
`timescale 1ns/1ps
module uphy_reset_config
    import uphy_pkg::*;
#(
    parameter logic [15:0] CLK_LIMIT =
        16'(uphy_pkg::CLK_AVAIL_CYCLES - uphy_pkg::SEQ_LATENCY),
    parameter logic [15:0] PIPE_LIMIT = 16'(uphy_pkg::PIPE_STATUS_CYCLES)
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic phyPowerOnReset,
    input wire logic captureAddressStrobe,
    input wire logic captureDataStrobe,
    input wire logic registerReadCommand,
    input wire logic registerWriteCommand,
    input wire logic [uphy_pkg::PORT_WIDTH-1:0] configPortDataIn,
    output logic accessAcknowledge,
    output logic [uphy_pkg::PORT_WIDTH-1:0] registerReadValue,
    output logic utmiSideClockValid,
    output logic legacyHostClock12Valid,
    output logic legacyHostClock48Valid,
    output logic pipeStatusIndication,
    output logic [1:0] referenceSourceActive,
    output logic [1:0] refFrequencySelect,
    output logic [1:0] linkPowerState,
    output logic hsSuspended
);
    import uphy_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        uphy_seq_t seq;
        logic [15:0] cnt;
        logic clkValid;
        logic pipeStat;
        uphy_port_t port;
        logic ack;
        logic [PORT_WIDTH-1:0] addr;
        logic [PORT_WIDTH-1:0] data;
        logic [PORT_WIDTH-1:0] readVal;
        logic [PORT_DEPTH-1:0][PORT_WIDTH-1:0] regs;
        logic [CTRL_W-1:0] ctrl;
        logic [1:0] refAct;
        logic [1:0] lpState;
        logic suspended;
        logic dataWrite;
        logic [ADDR_W-1:0] dataAddr;
        logic [31:0] rdata;
    } uphy_state_t;

    uphy_state_t s_q;
    uphy_state_t s_d;
    logic porSync;
    logic [CMD_COUNT-1:0] cmdSync;
    logic [PORT_WIDTH-1:0] dataSync;
    logic addrPhase;
    logic inRange;
    logic [PORT_WIDTH-1:0] ovr;
    logic [31:0] statusWord;

    // ==========================================================
    // Pin synchronisers
    uphy_sync #(.WIDTH(1 + CMD_COUNT), .INIT(5'h01)) u_syncCtl (
        .sys_clk(sys_clk),
        .srst(srst),
        .asyncIn({registerWriteCommand, registerReadCommand,
                  captureDataStrobe, captureAddressStrobe,
                  phyPowerOnReset}),
        .syncOut({cmdSync, porSync})
    );

    uphy_sync #(.WIDTH(PORT_WIDTH), .INIT(16'h0000)) u_syncData (
        .sys_clk(sys_clk),
        .srst(srst),
        .asyncIn(configPortDataIn),
        .syncOut(dataSync)
    );

    assign addrPhase = hsel && htrans[1] && hready;
    assign inRange = (s_q.addr[PORT_WIDTH-1:PORT_INDEX_W] == '0);
    assign ovr = s_q.regs[PORT_OVERRIDE_INDEX];

    always_comb
    begin
        statusWord = 32'h0000_0000;
        statusWord[ST_POR] = porSync;
        statusWord[ST_CLKVALID] = s_q.clkValid;
        statusWord[ST_PIPESTAT] = s_q.pipeStat;
        statusWord[ST_REFSRC_LSB +: 2] = s_q.refAct;
        statusWord[ST_LPSTATE_LSB +: 2] = s_q.lpState;
        statusWord[ST_SUSPEND] = s_q.suspended;
        statusWord[ST_FREQ_LSB +: 2] = s_q.ctrl[CTRL_FREQ_LSB +: 2];
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        s_d = s_q;

        // Reset sequencing.
        if (porSync)
        begin
            s_d.seq = SEQ_HELD;
            s_d.cnt = 16'h0000;
            s_d.clkValid = 1'b0;
            s_d.pipeStat = 1'b1;
        end
        else
        begin
            case (s_q.seq)
                SEQ_HELD:
                begin
                    s_d.seq = SEQ_RAMP;
                    s_d.cnt = 16'h0000;
                end
                SEQ_RAMP:
                begin
                    s_d.cnt = s_q.cnt + 16'h0001;
                    if (s_q.cnt == CLK_LIMIT - 16'h0001)
                    begin
                        s_d.clkValid = 1'b1;
                    end
                    if (s_q.cnt == PIPE_LIMIT - 16'h0001)
                    begin
                        s_d.pipeStat = 1'b0;
                        s_d.seq = SEQ_READY;
                    end
                end
                SEQ_READY:
                begin
                    s_d.seq = SEQ_READY;
                end
                default:
                begin
                    s_d.seq = SEQ_HELD;
                end
            endcase
        end

        // Config port four-phase handshake, one command at a time.
        case (s_q.port)
            PORT_IDLE:
            begin
                if (cmdSync != '0)
                begin
                    s_d.ack = 1'b1;
                    s_d.port = PORT_ACKING;
                    if (cmdSync[CMD_CAP_ADDR])
                    begin
                        s_d.addr = dataSync;
                    end
                    else if (cmdSync[CMD_CAP_DATA])
                    begin
                        s_d.data = dataSync;
                    end
                    else if (cmdSync[CMD_READ])
                    begin
                        s_d.readVal = inRange ?
                            s_q.regs[s_q.addr[PORT_INDEX_W-1:0]] :
                            16'h0000;
                    end
                    else if (inRange)
                    begin
                        s_d.regs[s_q.addr[PORT_INDEX_W-1:0]] = s_q.data;
                    end
                end
            end
            PORT_ACKING:
            begin
                if (cmdSync == '0)
                begin
                    s_d.ack = 1'b0;
                    s_d.port = PORT_IDLE;
                end
            end
            default:
            begin
                s_d.port = PORT_IDLE;
                s_d.ack = 1'b0;
            end
        endcase

        // Bus data phase of a write.
        if (s_q.dataWrite && s_q.dataAddr == REG_CTRL)
        begin
            s_d.ctrl = hwdata[CTRL_W-1:0];
            if (hwdata[CTRL_WAKE])
            begin
                s_d.ctrl[CTRL_SUSPEND] = 1'b0;
            end
        end

        // Bus address phase.
        s_d.dataWrite = addrPhase && hwrite;
        if (addrPhase)
        begin
            s_d.dataAddr = haddr[ADDR_W-1:0];
            s_d.rdata = 32'h0000_0000;
            if (!hwrite)
            begin
                case (haddr[ADDR_W-1:0])
                    REG_CTRL:
                    begin
                        s_d.rdata = {24'h00_0000, s_q.ctrl};
                    end
                    REG_STATUS:
                    begin
                        s_d.rdata = statusWord;
                    end
                    REG_PORT_VIEW:
                    begin
                        s_d.rdata = {s_q.data, s_q.addr};
                    end
                    default:
                    begin
                        s_d.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // PHY controls derived from software and port overrides.
        s_d.refAct = uphy_ref_decode(s_q.ctrl[CTRL_USEPAD],
                                     s_q.ctrl[CTRL_REFSEL_LSB +: 2]);
        s_d.lpState = ovr[OVR_EN] ? ovr[OVR_STATE_LSB +: 2] :
                      s_q.ctrl[CTRL_LPSTATE_LSB +: 2];
        s_d.suspended = s_q.ctrl[CTRL_SUSPEND];
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s_q <= '0;
            s_q.seq <= SEQ_HELD;
            s_q.pipeStat <= 1'b1;
            s_q.port <= PORT_IDLE;
            s_q.ctrl <= CTRL_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign accessAcknowledge = s_q.ack;
    assign registerReadValue = s_q.readVal;
    assign utmiSideClockValid = s_q.clkValid;
    assign legacyHostClock12Valid = s_q.clkValid;
    assign legacyHostClock48Valid = s_q.clkValid;
    assign pipeStatusIndication = s_q.pipeStat;
    assign referenceSourceActive = s_q.refAct;
    assign refFrequencySelect = s_q.ctrl[CTRL_FREQ_LSB +: 2];
    assign linkPowerState = s_q.lpState;
    assign hsSuspended = s_q.suspended;

    // ==========================================================
    // Checks
    AST_ACK_CAUSE: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(s_q.ack) |-> $past(cmdSync) != '0)
        else $error("Acknowledge rose without a command.");

    AST_ACK_RELEASE: assert property (@(posedge sys_clk) disable iff (srst)
        (s_q.ack && cmdSync == '0) |=> !s_q.ack)
        else $error("Acknowledge held after command release.");

    AST_WRITE_STORE: assert property (@(posedge sys_clk) disable iff (srst)
        (s_q.port == PORT_IDLE && cmdSync == 4'h8 && inRange) |=>
        s_q.regs[$past(s_q.addr[PORT_INDEX_W-1:0])] == $past(s_q.data))
        else $error("Config write did not store captured data.");

    AST_CLK_TIME: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(s_q.clkValid) |-> $past(s_q.cnt) == CLK_LIMIT - 16'h0001)
        else $error("Clock valid raised at the wrong count.");

    AST_PIPE_TIME: assert property (@(posedge sys_clk) disable iff (srst)
        $fell(s_q.pipeStat) |-> $past(s_q.cnt) == PIPE_LIMIT - 16'h0001)
        else $error("Pipe status dropped at the wrong count.");

    AST_PIPE_ORDER: assert property (@(posedge sys_clk) disable iff (srst)
        !s_q.pipeStat |-> s_q.clkValid)
        else $error("Pipe status dropped before clocks were valid.");

    AST_POR_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
        porSync |=> (!s_q.clkValid && s_q.pipeStat) [*2])
        else $error("Reset did not hold clocks invalid.");

    AST_REF_SELECT: assert property (@(posedge sys_clk) disable iff (srst)
        s_q.ctrl[CTRL_USEPAD] [*2] |-> s_q.refAct == REF_PAD)
        else $error("Pad reference not selected.");

    AST_OVERRIDE: assert property (@(posedge sys_clk) disable iff (srst)
        ovr[OVR_EN] |=> s_q.lpState == $past(ovr[OVR_STATE_LSB +: 2]))
        else $error("Port override did not set the power state.");

    AST_WAKE_CLEARS: assert property (@(posedge sys_clk) disable iff (srst)
        (s_q.dataWrite && s_q.dataAddr == REG_CTRL && hwdata[CTRL_WAKE])
        |-> ##2 !s_q.suspended)
        else $error("Remote wakeup did not leave suspend.");
endmodule

// >>> design/uphy_pkg.sv
// Purpose: Shared constants and types for the USB3 PHY reset and config port.
// Assumes: 200 MHz system clock, AHB-Lite register access.
// Notes: Timing counts are derived from the figures below.
package uphy_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int CLK_AVAIL_US = 45;
    localparam int PIPE_STATUS_US = 120;
    // Longest time, rounded down.
    localparam int CLK_AVAIL_CYCLES = CLK_AVAIL_US * CLK_MHZ;
    // Strictly greater than the figure, so one cycle beyond it.
    localparam int PIPE_STATUS_CYCLES = PIPE_STATUS_US * CLK_MHZ + 1;
    // Cycles spent in the input synchroniser and the release step.
    localparam int SEQ_LATENCY = 4;

    // ==========================================================
    // Config port geometry
    localparam int PORT_WIDTH = 16;
    localparam int PORT_DEPTH = 16;
    localparam int PORT_INDEX_W = 4;
    localparam int CMD_COUNT = 4;
    localparam int CMD_CAP_ADDR = 0;
    localparam int CMD_CAP_DATA = 1;
    localparam int CMD_READ = 2;
    localparam int CMD_WRITE = 3;
    localparam logic [PORT_INDEX_W-1:0] PORT_OVERRIDE_INDEX = 4'h0;
    localparam int OVR_EN = 0;
    localparam int OVR_STATE_LSB = 1;

    // ==========================================================
    // Bus register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_PORT_VIEW = 8'h08;
    localparam int CTRL_W = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam int CTRL_REFSEL_LSB = 0;
    localparam int CTRL_USEPAD = 2;
    localparam int CTRL_FREQ_LSB = 3;
    localparam int CTRL_LPSTATE_LSB = 5;
    localparam int CTRL_SUSPEND = 7;
    localparam int CTRL_WAKE = 8;
    localparam int ST_POR = 0;
    localparam int ST_CLKVALID = 1;
    localparam int ST_PIPESTAT = 2;
    localparam int ST_REFSRC_LSB = 3;
    localparam int ST_LPSTATE_LSB = 5;
    localparam int ST_SUSPEND = 7;
    localparam int ST_FREQ_LSB = 8;
    localparam int VIEW_DATA_LSB = 16;

    // ==========================================================
    // Types
    typedef enum logic [1:0]
    {
        REF_ALT = 2'b00,
        REF_PAD = 2'b01,
        REF_EXT = 2'b10
    } uphy_ref_t;

    typedef enum logic [1:0]
    {
        SEQ_HELD = 2'b00,
        SEQ_RAMP = 2'b01,
        SEQ_READY = 2'b10
    } uphy_seq_t;

    typedef enum logic
    {
        PORT_IDLE = 1'b0,
        PORT_ACKING = 1'b1
    } uphy_port_t;

    // Picks the reference source from the pad flag and the select field.
    function automatic uphy_ref_t uphy_ref_decode(input logic usePad,
                                                  input logic [1:0] sel);
        uphy_ref_t r;
        r = REF_EXT;
        if (usePad)
        begin
            r = REF_PAD;
        end
        else if (sel == 2'b00)
        begin
            r = REF_ALT;
        end
        return r;
    endfunction

endpackage

// >>> design/uphy_sync.sv
// Purpose: Two-stage synchroniser for pins entering the system clock domain.
// Assumes: Multi-bit inputs are held stable while they are sampled.
// Notes: Only the second stage is visible to the rest of the design.
`timescale 1ns/1ps
module uphy_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } uphy_sync_state_t;

    uphy_sync_state_t s_q;
    uphy_sync_state_t s_d;

    always_comb
    begin
        s_d.stage1 = asyncIn;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s_q <= {INIT, INIT};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign syncOut = s_q.stage2;
endmodule

// >>> dv/uphy_ctrl_model.sv
// Purpose: Model of the on-chip logic that resets and configures the PHY.
// Assumes: The PHY samples every command pin through synchronisers.
// Notes: The idle data bus shows the inverse of its last value.
`timescale 1ns/1ps
module uphy_ctrl_model
    import uphy_pkg::*;
#(
    parameter int HOLD_CYCLES = 2001
) (
    input wire logic sys_clk,
    input wire logic accessAcknowledge,
    output logic phyPowerOnReset,
    output logic captureAddressStrobe,
    output logic captureDataStrobe,
    output logic registerReadCommand,
    output logic registerWriteCommand,
    output logic [uphy_pkg::PORT_WIDTH-1:0] configPortDataIn
);
    logic [CMD_COUNT-1:0] cmdLines;
    int stalls;

    assign captureAddressStrobe = cmdLines[CMD_CAP_ADDR];
    assign captureDataStrobe = cmdLines[CMD_CAP_DATA];
    assign registerReadCommand = cmdLines[CMD_READ];
    assign registerWriteCommand = cmdLines[CMD_WRITE];

    initial
    begin
        phyPowerOnReset = 1'b1;
        cmdLines = '0;
        configPortDataIn = 16'h0000;
        stalls = 0;
    end

    // Supplies and reference are taken as good when this task is called, so the
    // hold counts from there; HOLD_CYCLES is just over 10 us.
    task automatic releaseReset();
        repeat (HOLD_CYCLES) @(posedge sys_clk);
        phyPowerOnReset <= 1'b0;
    endtask

    task automatic waitAck(input logic level);
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (accessAcknowledge !== level && n < 200);
        if (n >= 200)
        begin
            stalls++;
        end
    endtask

    // One full handshake; a new command waits for the old acknowledge.
    task automatic cmd(input int kind, input logic [15:0] val);
        @(posedge sys_clk);
        configPortDataIn <= val;
        @(posedge sys_clk);
        cmdLines[kind] <= 1'b1;
        waitAck(1'b1);
        cmdLines[kind] <= 1'b0;
        waitAck(1'b0);
        configPortDataIn <= ~val;
    endtask
endmodule

// >>> dv/usb3_phy_reset_and_config_port_test.sv
// Purpose: Self-checking bench for the PHY reset and config port block.
// Assumes: The controller model drives the reset pin and command pins.
// Notes: Short sequencer limits keep the run brief.
`timescale 1ns/1ps
module usb3_phy_reset_and_config_port_test;
    import uphy_pkg::*;

    localparam logic [15:0] CLK_LIM = 16'h0014;
    localparam logic [15:0] PIPE_LIM = 16'h0028;

    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, ackLine, por, capA, capD, rdCmd, wrCmd;
    logic [31:0] hrdata;
    logic [15:0] portIn, readVal;
    logic clkValid, clk12Valid, clk48Valid, pipeStatus, suspended;
    logic [1:0] refActive, freqSel, powerState;
    int errors = 0;
    int samples_checked = 0;

    always #2.5 sys_clk = ~sys_clk;

    uphy_ctrl_model ctl (.sys_clk(sys_clk), .accessAcknowledge(ackLine),
        .phyPowerOnReset(por), .captureAddressStrobe(capA),
        .captureDataStrobe(capD), .registerReadCommand(rdCmd),
        .registerWriteCommand(wrCmd), .configPortDataIn(portIn));

    uphy_reset_config #(.CLK_LIMIT(CLK_LIM), .PIPE_LIMIT(PIPE_LIM)) dut (
        .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .phyPowerOnReset(por),
        .captureAddressStrobe(capA), .captureDataStrobe(capD),
        .registerReadCommand(rdCmd), .registerWriteCommand(wrCmd),
        .configPortDataIn(portIn), .accessAcknowledge(ackLine),
        .registerReadValue(readVal), .utmiSideClockValid(clkValid),
        .legacyHostClock12Valid(clk12Valid),
        .legacyHostClock48Valid(clk48Valid),
        .pipeStatusIndication(pipeStatus),
        .referenceSourceActive(refActive), .refFrequencySelect(freqSel),
        .linkPowerState(powerState), .hsSuspended(suspended));

    // ==========================================================
    // Checking and closing
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic checkRange(input int n, input int lo, input int hi);
        samples_checked++;
        if (n < lo || n > hi)
        begin
            errors++;
            $display("[FAIL] %0t delay %0d outside %0d..%0d", $time, n, lo,
                hi);
        end
    endtask

    task automatic summarize();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // Bus and port helpers
    task automatic waitReady();
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
    endtask

    task automatic busCycle(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        waitReady();
        q = hrdata;
    endtask

    task automatic cfgWrite(input logic [15:0] a, input logic [15:0] d);
        ctl.cmd(CMD_CAP_ADDR, a);
        ctl.cmd(CMD_CAP_DATA, d);
        ctl.cmd(CMD_WRITE, 16'h0000);
    endtask

    task automatic cfgRead(input logic [15:0] a);
        ctl.cmd(CMD_CAP_ADDR, a);
        ctl.cmd(CMD_READ, 16'h0000);
    endtask

    // ==========================================================
    // Scenarios
    task automatic testResetState();
        logic [31:0] q;
        compare({30'h0, hreadyout, hresp}, 32'h2);
        compare({28'h0, clkValid, clk12Valid, clk48Valid, pipeStatus},
            32'h1);
        busCycle(1'b0, REG_STATUS, 32'h0, q);
        compare(q, 32'h5);
    endtask

    task automatic testConfigPort();
        logic [31:0] q;
        cfgWrite(16'h0003, 16'hA5C3);
        cfgWrite(16'h000F, 16'h5A3C);
        cfgRead(16'h0003);
        compare({16'h0, readVal}, 32'h0000A5C3);
        busCycle(1'b0, REG_PORT_VIEW, 32'h0, q);
        compare(q, 32'h5A3C0003);
        cfgRead(16'h000F);
        compare({16'h0, readVal}, 32'h00005A3C);
        cfgWrite(16'h0010, 16'hFFFF);
        cfgRead(16'h0010);
        compare({16'h0, readVal}, 32'h0);
    endtask

    task automatic testPorSequence();
        int n;
        n = 0;
        ctl.releaseReset();
        while (clkValid !== 1'b1 && n < 500)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        checkRange(n, int'(CLK_LIM), int'(CLK_LIM) + SEQ_LATENCY);
        compare({31'h0, clk12Valid & clk48Valid}, 32'h1);
        while (pipeStatus !== 1'b0 && n < 500)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        checkRange(n, int'(PIPE_LIM), int'(PIPE_LIM) + SEQ_LATENCY);
    endtask

    task automatic testControl();
        logic [31:0] q;
        logic [2:0] padSel [4];
        logic [1:0] src [4];
        logic [1:0] i2;
        padSel = '{3'b000, 3'b001, 3'b110, 3'b011};
        src = '{2'b00, 2'b10, 2'b01, 2'b10};
        for (int i = 0; i < 4; i++)
        begin
            i2 = 2'(i);
            busCycle(1'b1, REG_CTRL, {24'h0, 1'b0, i2, i2, padSel[i]}, q);
            repeat (3) @(posedge sys_clk);
            compare({26'h0, refActive, freqSel, powerState},
                {26'h0, src[i], i2, i2});
            busCycle(1'b0, REG_STATUS, 32'h0, q);
            compare(q, {22'h0, i2, 1'b0, i2, src[i], 3'b010});
        end
        busCycle(1'b1, REG_CTRL, 32'h80, q);
        repeat (3) @(posedge sys_clk);
        compare({31'h0, suspended}, 32'h1);
        busCycle(1'b1, REG_CTRL, 32'h180, q);
        repeat (3) @(posedge sys_clk);
        compare({31'h0, suspended}, 32'h0);
        busCycle(1'b0, 8'h0C, 32'h0, q);
        compare(q, 32'h0);
    endtask

    task automatic testOverride();
        cfgWrite(16'h0000, 16'h0007);
        repeat (3) @(posedge sys_clk);
        compare({30'h0, powerState}, 32'h3);
        cfgWrite(16'h0000, 16'h0006);
        repeat (3) @(posedge sys_clk);
        compare({30'h0, powerState}, 32'h0);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        testResetState();
        testConfigPort();
        testPorSequence();
        testControl();
        testOverride();
        compare(32'(ctl.stalls), 32'h0);
        summarize();
    end

    initial
    begin
        #100000;
        errors++;
        summarize();
    end
endmodule
